/* rtl/clk_sel.sv */
// clock source select, stop-mode run control and interrupt gating
// assumes pll lock and oscillator filter status arrive asynchronously;
// stop, mode, tick and watchdog events come from logic on clk_i
//
// Implementation choice: the Wishbone slave port.
module clk_sel (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // status from pll, oscillator and mode logic
  input  wire logic        pll_lock_i,
  input  wire logic        osc_filter_good_i,
  input  wire logic        osc_enable_i,
  input  wire logic        special_mode_i,
  input  wire logic        stop_i,
  input  wire logic        tick_timeout_i,
  input  wire logic        wdog_ctrl_write_i,
  // clock control outputs
  output logic             pll_clock_select_o,
  output logic             pll_keep_on_o,
  output logic             pll_unlocked_div4_o,
  output logic             osc_run_in_stop_o,
  output logic             tick_clock_select_o,
  output logic             wdog_clock_select_o,
  output logic             tick_run_o,
  output logic             wdog_run_o,
  output logic             tick_restart_o,
  output logic             wdog_restart_o,
  // interrupt requests
  output logic             tick_irq_o,
  output logic             lock_irq_o,
  output logic             osc_irq_o
);

  // synchronisers for asynchronous status, then status history and register state
  logic lock_s1_ff, lock_s2_ff, good_s1_ff, good_s2_ff;
  logic lock_prev_ff, qual_ff, qual_prev_ff, stop_prev_ff;
  logic [7:0] sel_ff, irq_en_ff;
  logic clock_reg_protect_ff, ack_ff, wdog_locked_ff, wdog_rearm_ff;
  logic tick_flag_ff, lock_flag_ff, osc_flag_ff;
  logic [31:0] dat_ff;
  logic [7:0] nxt_sel;
  logic nxt_qual, nxt_rearm;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
      good_s1_ff <= 1'b0;
      good_s2_ff <= 1'b0;
    end else begin
      lock_s1_ff <= pll_lock_i;
      lock_s2_ff <= lock_s1_ff;
      good_s1_ff <= osc_filter_good_i;
      good_s2_ff <= good_s1_ff;
    end
  end

  // bus decode; answer comes one cycle after the request
  wire req      = cyc_i & stb_i & ~ack_ff;
  wire wr_lane  = req & we_i & sel_i[0];
  wire hit_flg  = adr_i == clk_sel_pkg::ADR_FLAGS;
  wire hit_irq  = adr_i == clk_sel_pkg::ADR_IRQ_EN;
  wire hit_sel  = adr_i == clk_sel_pkg::ADR_CLK_SEL;
  wire hit_clock_reg_protect = adr_i == clk_sel_pkg::ADR_PROTECT;
  wire wr_flg   = wr_lane & hit_flg;
  wire wr_irq   = wr_lane & hit_irq;
  wire wr_sel   = wr_lane & hit_sel & ~clock_reg_protect_ff;
  wire wr_clock_reg_protect  = wr_lane & hit_clock_reg_protect;
  wire [7:0] wd = dat_i[7:0];

  // stop mode decode
  wire stop_entry   = stop_i & ~stop_prev_ff;
  wire pseudo_stop  = stop_i & sel_ff[clk_sel_pkg::SEL_OSC_RUN_IN_STOP];
  wire full_entry   = stop_entry & ~sel_ff[clk_sel_pkg::SEL_OSC_RUN_IN_STOP];

  // qualified status needs both filter and vco; lock loss on pseudo
  // stop entry is tolerated since the oscillator keeps running
  always_comb begin
    nxt_qual = good_s2_ff & (lock_s2_ff | pseudo_stop);
    if (full_entry) begin
      nxt_qual = 1'b0;
    end
  end
  wire qual_drop = qual_prev_ff & ~qual_ff;

  // software write view of the select register
  wire wd_sel_ok   = special_mode_i | ~wdog_locked_ff | wdog_rearm_ff;
  wire [7:0] wmask = special_mode_i ? 8'hff : clk_sel_pkg::SEL_NORMAL_MASK;

  // select register next value: write, then hardware overrides
  always_comb begin
    nxt_sel = sel_ff;
    if (wr_sel) begin
      nxt_sel = (sel_ff & ~wmask) | (wd & wmask);
      if (wd_sel_ok) begin
        nxt_sel[clk_sel_pkg::SEL_WCLK] = wd[clk_sel_pkg::SEL_WCLK];
      end
    end
    nxt_sel[5:4] = 2'h0;
    if (!qual_ff) begin
      nxt_sel[clk_sel_pkg::SEL_PLL]  = 1'b1;
      nxt_sel[clk_sel_pkg::SEL_TCLK] = 1'b0;
      nxt_sel[clk_sel_pkg::SEL_WCLK] = 1'b0;
    end
    if (full_entry) begin
      nxt_sel[clk_sel_pkg::SEL_PLL] = 1'b1;
    end
  end

  // one extra watchdog select set allowed after oscillator loss while the watchdog select was set
  always_comb begin
    nxt_rearm = wdog_rearm_ff;
    if (!qual_ff && sel_ff[clk_sel_pkg::SEL_WCLK]) begin
      nxt_rearm = 1'b1;
    end else if (wr_sel && !special_mode_i && wdog_locked_ff &&
                 nxt_sel[clk_sel_pkg::SEL_WCLK]) begin
      nxt_rearm = 1'b0;
    end
  end

  // status history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_prev_ff <= 1'b0;
      qual_ff      <= 1'b0;
      qual_prev_ff <= 1'b0;
      stop_prev_ff <= 1'b0;
    end else begin
      lock_prev_ff <= lock_s2_ff;
      qual_ff      <= nxt_qual;
      qual_prev_ff <= qual_ff;
      stop_prev_ff <= stop_i;
    end
  end

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_ff         <= clk_sel_pkg::SEL_RESET;
      irq_en_ff      <= clk_sel_pkg::IRQ_EN_RESET;
      clock_reg_protect_ff        <= clk_sel_pkg::CLOCK_REG_PROTECT_RESET;
      wdog_locked_ff <= 1'b0;
      wdog_rearm_ff  <= 1'b0;
    end else begin
      sel_ff        <= nxt_sel;
      wdog_rearm_ff <= nxt_rearm;
      if (wr_irq) begin
        irq_en_ff <= wd & clk_sel_pkg::IRQ_EN_MASK;
      end
      if (wr_clock_reg_protect) begin
        clock_reg_protect_ff <= wd[clk_sel_pkg::CLOCK_REG_PROTECT_BIT];
      end
      if (wdog_ctrl_write_i) begin
        wdog_locked_ff <= 1'b1;
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  wire lock_chg = lock_s2_ff ^ lock_prev_ff;
  wire qual_chg = qual_ff ^ qual_prev_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_flag_ff <= 1'b0;
      lock_flag_ff <= 1'b0;
      osc_flag_ff  <= 1'b0;
    end else begin
      tick_flag_ff <= tick_timeout_i |
                      (tick_flag_ff & ~(wr_flg & wd[clk_sel_pkg::IRQ_TICK]));
      lock_flag_ff <= lock_chg |
                      (lock_flag_ff & ~(wr_flg & wd[clk_sel_pkg::IRQ_LOCK]));
      osc_flag_ff  <= qual_chg |
                      (osc_flag_ff & ~(wr_flg & wd[clk_sel_pkg::IRQ_OSC]));
    end
  end

  // read mux; unmapped reads return zero
  logic [7:0] flags_rd;
  always_comb begin
    flags_rd = 8'h00;
    flags_rd[clk_sel_pkg::IRQ_TICK]    = tick_flag_ff;
    flags_rd[clk_sel_pkg::IRQ_LOCK]    = lock_flag_ff;
    flags_rd[clk_sel_pkg::FLG_LOCK_ST] = lock_s2_ff;
    flags_rd[clk_sel_pkg::IRQ_OSC]     = osc_flag_ff;
    flags_rd[clk_sel_pkg::FLG_QUAL]    = qual_ff;
  end
  wire [7:0] rd = hit_flg  ? flags_rd :
                  hit_irq  ? irq_en_ff :
                  hit_sel  ? sel_ff :
                  hit_clock_reg_protect ? {7'h00, clock_reg_protect_ff} : 8'h00;

  // answer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= req;
      if (req) begin
        dat_ff <= {24'h0, rd};
      end
    end
  end

  // stop-mode run gating freezes counters; full stop entry clears the oscillator selects, which pulses restart
  wire tick_run = ~stop_i | (pseudo_stop & sel_ff[clk_sel_pkg::SEL_TRUN] &
                  sel_ff[clk_sel_pkg::SEL_TCLK]);
  wire wdog_run = ~stop_i | (pseudo_stop & sel_ff[clk_sel_pkg::SEL_WRUN] &
                  sel_ff[clk_sel_pkg::SEL_WCLK]);

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_clock_select_o  <= 1'b1;
      pll_keep_on_o       <= 1'b1;
      pll_unlocked_div4_o <= 1'b1;
      osc_run_in_stop_o   <= 1'b0;
      tick_clock_select_o <= 1'b0;
      wdog_clock_select_o <= 1'b0;
      tick_run_o          <= 1'b1;
      wdog_run_o          <= 1'b1;
      tick_restart_o      <= 1'b0;
      wdog_restart_o      <= 1'b0;
      tick_irq_o          <= 1'b0;
      lock_irq_o          <= 1'b0;
      osc_irq_o           <= 1'b0;
    end else begin
      pll_clock_select_o  <= sel_ff[clk_sel_pkg::SEL_PLL];
      pll_keep_on_o       <= 1'b1;
      pll_unlocked_div4_o <= ~lock_s2_ff;
      osc_run_in_stop_o   <= sel_ff[clk_sel_pkg::SEL_OSC_RUN_IN_STOP];
      tick_clock_select_o <= sel_ff[clk_sel_pkg::SEL_TCLK];
      wdog_clock_select_o <= sel_ff[clk_sel_pkg::SEL_WCLK];
      tick_run_o          <= tick_run;
      wdog_run_o          <= wdog_run;
      tick_restart_o      <= nxt_sel[clk_sel_pkg::SEL_TCLK] ^
                             sel_ff[clk_sel_pkg::SEL_TCLK];
      wdog_restart_o      <= nxt_sel[clk_sel_pkg::SEL_WCLK] ^
                             sel_ff[clk_sel_pkg::SEL_WCLK];
      tick_irq_o <= tick_flag_ff & irq_en_ff[clk_sel_pkg::IRQ_TICK];
      lock_irq_o <= lock_flag_ff & irq_en_ff[clk_sel_pkg::IRQ_LOCK];
      osc_irq_o  <= osc_flag_ff & irq_en_ff[clk_sel_pkg::IRQ_OSC];
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

endmodule : clk_sel

/* rtl/clk_sel_pkg.sv */
// constants for the clock select and interrupt enable block
// assumes a 32-bit classic wishbone bus, 8-bit registers in lane 0
package clk_sel_pkg;
  // byte addresses
  localparam logic [7:0] ADR_FLAGS   = 8'h34;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h38;
  localparam logic [7:0] ADR_CLK_SEL = 8'h3c;
  localparam logic [7:0] ADR_PROTECT = 8'h40;
  // clock_source_select fields
  localparam int SEL_PLL   = 7;
  localparam int SEL_OSC_RUN_IN_STOP  = 6;
  localparam int SEL_TRUN  = 3;
  localparam int SEL_WRUN  = 2;
  localparam int SEL_TCLK  = 1;
  localparam int SEL_WCLK  = 0;
  // mask of bits writable in normal mode, watchdog select handled apart
  localparam logic [7:0] SEL_NORMAL_MASK = 8'hce;
  localparam logic [7:0] SEL_RESET       = 8'h80;
  // clock_interrupt_enable fields and flags share positions
  localparam int IRQ_TICK  = 7;
  localparam int IRQ_LOCK  = 4;
  localparam int IRQ_OSC   = 1;
  localparam logic [7:0] IRQ_EN_MASK  = 8'h92;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam int FLG_LOCK_ST = 3;
  localparam int FLG_QUAL    = 0;
  localparam int CLOCK_REG_PROTECT_BIT    = 0;
  localparam logic CLOCK_REG_PROTECT_RESET = 1'b0;
  // pll output divider while unlocked
  localparam logic [2:0] UNLOCKED_DIV = 3'h4;
  // bus clock divider from selected source
  localparam logic [1:0] BUS_DIV = 2'h2;
endpackage : clk_sel_pkg

/* verif/clk_sel_bench.sv */
// bench for clk_sel: wishbone reads compared with a bench model
// assumes the checker is bound to clk_sel
module clk_sel_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00, msel = 8'h80, d, q;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rs = 32'd95459;
  logic        pll_lock_i = 1'b0, osc_filter_good_i = 1'b0, osc_enable_i = 1'b1;
  logic        special_mode_i = 1'b0, stop_i = 1'b0, tick_timeout_i = 1'b0;
  logic        wdog_ctrl_write_i = 1'b0, spc = 1'b0, wok = 1'b1, wlk = 1'b0;
  logic        clock_reg_protect = 1'b0, qual = 1'b0, ack_o, pll_clock_select_o, pll_keep_on_o;
  logic        pll_unlocked_div4_o, osc_run_in_stop_o, tick_clock_select_o;
  logic        wdog_clock_select_o, tick_run_o, wdog_run_o, tick_restart_o;
  logic        wdog_restart_o, tick_irq_o, lock_irq_o, osc_irq_o;
  int          mismatches = 0, tests_run = 0, cycles = 0;
  clk_sel dut_u (.*);
  initial forever #50 clk_i = ~clk_i;
  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // one classic cycle; the answer is awaited, never assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {1'b1, 1'b1, w, a, 24'h0, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    r = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask : rd
  // model: protect, mode mask, watchdog lock, then qualified forcing
  task automatic wsel(input logic [7:0] v);
    logic [7:0] m;
    m = spc ? 8'hcf : (clk_sel_pkg::SEL_NORMAL_MASK | {7'h0, wok});
    wb(1'b1, clk_sel_pkg::ADR_CLK_SEL, v, q);
    if (!clock_reg_protect) msel = (msel & ~m) | (v & m);
    if (!qual) msel = (msel & 8'hfc) | 8'h80;
    if (wlk) wok = 1'b0;
  endtask : wsel
  task automatic poll(input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, clk_sel_pkg::ADR_FLAGS, 8'h00, q);
      n++;
    end while (q[0] !== v && n < 12);
    chk({7'h0, q[0]}, {7'h0, v});
  endtask : poll
  task automatic end_of_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(clk_sel_pkg::ADR_IRQ_EN, clk_sel_pkg::IRQ_EN_RESET);
    rd(clk_sel_pkg::ADR_CLK_SEL, clk_sel_pkg::SEL_RESET);
    rd(clk_sel_pkg::ADR_PROTECT, 8'h00);
    rd(8'h50, 8'h00);
    wsel(8'h4f);
    rd(clk_sel_pkg::ADR_CLK_SEL, msel);
    repeat (4) begin
      d = rnd();
      wb(1'b1, clk_sel_pkg::ADR_IRQ_EN, d, q);
      rd(clk_sel_pkg::ADR_IRQ_EN, d & clk_sel_pkg::IRQ_EN_MASK);
    end
    wb(1'b1, clk_sel_pkg::ADR_IRQ_EN, 8'h92, q);
    pll_lock_i <= 1'b1;
    osc_filter_good_i <= 1'b1;
    poll(1'b1);
    qual = 1'b1;
    rd(clk_sel_pkg::ADR_FLAGS, 8'h1b);
    chk({6'h0, lock_irq_o, osc_irq_o}, 8'h03);
    wb(1'b1, clk_sel_pkg::ADR_FLAGS, 8'h00, q);
    rd(clk_sel_pkg::ADR_FLAGS, 8'h1b);
    wb(1'b1, clk_sel_pkg::ADR_FLAGS, 8'h12, q);
    rd(clk_sel_pkg::ADR_FLAGS, 8'h09);
    @(posedge clk_i) tick_timeout_i <= 1'b1;
    @(posedge clk_i) tick_timeout_i <= 1'b0;
    rd(clk_sel_pkg::ADR_FLAGS, 8'h89);
    chk({5'h0, tick_irq_o, lock_irq_o, osc_irq_o}, 8'h04);
    wb(1'b1, clk_sel_pkg::ADR_IRQ_EN, 8'h12, q);
    rd(clk_sel_pkg::ADR_FLAGS, 8'h89);
    chk({7'h0, tick_irq_o}, 8'h00);
    wsel(8'h4f);
    rd(clk_sel_pkg::ADR_CLK_SEL, msel);
    chk({5'h0, pll_clock_select_o, tick_clock_select_o, wdog_clock_select_o}, 8'h03);
    wb(1'b1, clk_sel_pkg::ADR_PROTECT, 8'h01, q);
    clock_reg_protect = 1'b1;
    wsel(8'hc0);
    rd(clk_sel_pkg::ADR_CLK_SEL, msel);
    wb(1'b1, clk_sel_pkg::ADR_PROTECT, 8'h00, q);
    clock_reg_protect = 1'b0;
    @(posedge clk_i) wdog_ctrl_write_i <= 1'b1;
    @(posedge clk_i) wdog_ctrl_write_i <= 1'b0;
    wlk = 1'b1;
    wok = 1'b0;
    wsel(8'h4a);
    rd(clk_sel_pkg::ADR_CLK_SEL, msel);
    // oscillator was qualified long before, so start-up wait is met
    @(posedge clk_i) stop_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({6'h0, tick_run_o, wdog_run_o}, 8'h02);
    stop_i <= 1'b0;
    osc_filter_good_i <= 1'b0;
    poll(1'b0);
    qual = 1'b0;
    if (msel[0]) wok = 1'b1;
    msel = (msel & 8'hfc) | 8'h80;
    rd(clk_sel_pkg::ADR_CLK_SEL, msel);
    osc_filter_good_i <= 1'b1;
    poll(1'b1);
    qual = 1'b1;
    wsel(8'h01);
    rd(clk_sel_pkg::ADR_CLK_SEL, msel);
    special_mode_i <= 1'b1;
    spc = 1'b1;
    wsel(8'h00);
    rd(clk_sel_pkg::ADR_CLK_SEL, msel);
    @(posedge clk_i) stop_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(clk_sel_pkg::ADR_CLK_SEL, 8'h80);
    end_of_test();
  end
endmodule : clk_sel_bench

/* verif/clk_sel_checker.sv */
// concurrent checks on the clk_sel ports
// assumes one clock domain and a synchronous active-high reset
module clk_sel_checker (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pll_lock_i,
  input wire logic osc_filter_good_i,
  input wire logic stop_i,
  input wire logic pll_clock_select_o,
  input wire logic pll_keep_on_o,
  input wire logic pll_unlocked_div4_o,
  input wire logic osc_run_in_stop_o,
  input wire logic tick_clock_select_o,
  input wire logic wdog_clock_select_o,
  input wire logic tick_run_o,
  input wire logic wdog_run_o,
  input wire logic tick_restart_o,
  input wire logic wdog_restart_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // the filter needs the vco, so the pll may never be dropped
  property p_keep_on; pll_keep_on_o; endproperty
  a_keep_on: assert property (p_keep_on) else $error("pll keep-on low");
  // sync delay is short, six steady cycles are ample
  property p_div4; $stable(pll_lock_i) [*6] |-> pll_unlocked_div4_o == !pll_lock_i; endproperty
  a_div4: assert property (p_div4) else $error("divide-by-four flag wrong");
  property p_qual_loss; !osc_filter_good_i [*8] |-> pll_clock_select_o; endproperty
  a_qual_loss: assert property (p_qual_loss) else $error("pll select not forced");
  property p_src_loss;
    !osc_filter_good_i [*8] |-> !tick_clock_select_o && !wdog_clock_select_o;
  endproperty
  a_src_loss: assert property (p_src_loss) else $error("osc source kept");
  property p_full_stop; (stop_i && !osc_run_in_stop_o) [*4] |-> pll_clock_select_o; endproperty
  a_full_stop: assert property (p_full_stop) else $error("full stop kept osc");
  // restart may lead or trail the visible select bit by one cycle
  property p_restart;
    $changed(tick_clock_select_o) |-> (tick_restart_o || $past(tick_restart_o)) or (##1 tick_restart_o);
  endproperty
  a_restart: assert property (p_restart) else $error("tick restart missing");
  property p_wrestart;
    $changed(wdog_clock_select_o) |-> (wdog_restart_o || $past(wdog_restart_o)) or (##1 wdog_restart_o);
  endproperty
  a_wrestart: assert property (p_wrestart) else $error("wdog restart missing");
  property p_tick_stop; (stop_i && !tick_clock_select_o) [*3] |-> !tick_run_o; endproperty
  a_tick_stop: assert property (p_tick_stop) else $error("tick runs in stop");
  property p_wdog_stop; (stop_i && !osc_run_in_stop_o) [*3] |-> !wdog_run_o; endproperty
  a_wdog_stop: assert property (p_wdog_stop) else $error("wdog runs in stop");
endmodule : clk_sel_checker

bind clk_sel clk_sel_checker chk_u (.*);
